// [hw/link_cfg.svh]
// Register indices, field positions, reset values and lane identifiers of the link configuration bank.
`ifndef LINK_CFG_SVH
`define LINK_CFG_SVH

// ****************************************************************
// Register indices; the byte address on the bus is four times these.
// ****************************************************************
`define IDX_SUBCLASS_BITS   16'h0590
`define IDX_SAMPLES_FRAME   16'h0591
`define IDX_DENSITY_CTRL    16'h0592
`define IDX_LANE0_CKSUM     16'h05a0
`define IDX_LANE1_CKSUM     16'h05a1
`define IDX_LANE_PDOWN      16'h05b0
`define IDX_LANE0_ASSIGN    16'h05b2

// ****************************************************************
// Field positions.
// ****************************************************************
`define SUBCLASS_MSB        7
`define SUBCLASS_LSB        5
`define NP_MSB              4
`define NP_LSB              0
`define HD_BIT              7
`define PDOWN_LANE1_BIT     2
`define PDOWN_LANE0_BIT     0
`define ASSIGN_RSV_MSB      6
`define ASSIGN_RSV_LSB      4
`define ASSIGN_SEL_MSB      2
`define ASSIGN_SEL_LSB      0

// ****************************************************************
// Reset values, fixed read values and lane identifiers.
// ****************************************************************
`define RST_SUBCLASS_BITS   8'h2f
`define RST_LANE_PDOWN      8'hfa
`define RST_LANE0_ASSIGN    8'h00
`define RST_LANE0_CKSUM     8'hc3
`define RST_LANE1_CKSUM     8'hc4
`define SAMPLES_RSV_VALUE   3'h1
`define LANE0_LID           5'h00
`define LANE1_LID           5'h01

`endif

// [hw/link_pkg.sv]
// Types shared by the link configuration bank and its helpers.
package link_pkg;

    // Link parameters reported by the framer, read-only to software.
    typedef struct packed {
        logic       hd;
        logic [4:0] cf;
        logic [4:0] s_field;
    } link_report_t;

    // Link parameters held elsewhere in the bank that enter the checksum.
    typedef struct packed {
        logic [7:0] did;
        logic [3:0] bid;
        logic       scr;
        logic [4:0] l_m1;
        logic [7:0] f_m1;
        logic [4:0] k_m1;
        logic [7:0] m_m1;
        logic [1:0] cs;
        logic [4:0] n_m1;
        logic [2:0] jesdv;
    } link_static_t;

    // Everything that one lane checksum adds up except the lane number.
    typedef struct packed {
        link_static_t st;
        link_report_t rep;
        logic [4:0]   np_m1;
        logic [2:0]   subclass;
    } cksum_in_t;

    // One write taken from the register bus.
    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } reg_wr_t;

    // Four logical lane words offered to the lane crossbar.
    typedef logic [3:0][7:0] lane_bus_t;

    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;

endpackage : link_pkg

// [hw/axil_reg_slave.sv]
// AXI4-Lite slave front end with one write and one read in flight.
`timescale 1ns/1ps
module axil_reg_slave
    import link_pkg::*;
(
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Write channels.
    input  wire logic [15:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // Read channels.
    input  wire logic [15:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Register side.
    output logic             wr_en,
    output reg_wr_t          wr,
    input  wire logic        wr_ok,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_ok
);
    // Address and data are held until both have arrived.
    assign wr_en = !awready && !wready && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            wr      <= '0;
        end else begin
            if (awvalid && awready) begin
                wr.addr <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wr.data <= wdata;
                wr.strb <= wstrb;
                wready  <= 1'b0;
            end
            if (wr_en) begin
                bvalid <= 1'b1;
                bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Read data is captured from the decode on the address handshake.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_ok ? rd_data : 32'h00000000;
            rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

endmodule : axil_reg_slave

// [hw/lane_checksum.sv]
// Per-lane configuration checksum, the modulo 256 sum of the lane's link parameters.
`timescale 1ns/1ps
module lane_checksum
    import link_pkg::*;
#(
    parameter logic [4:0] LANE_ID   = 5'h00,
    parameter logic [7:0] RST_VALUE = 8'h00
)
(
    // Clock and reset.
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Parameters and result.
    input  wire cksum_in_t  p,
    output logic      [7:0] sum_reg
);
    logic [7:0] sum_next;

    // Eight-bit adds drop the carries, which is the modulo 256.
    always_comb begin
        sum_next = p.st.did + 8'(p.st.bid) + 8'(LANE_ID) + 8'(p.st.scr)
                 + 8'(p.st.l_m1) + p.st.f_m1 + 8'(p.st.k_m1) + p.st.m_m1
                 + 8'(p.st.cs) + 8'(p.st.n_m1) + 8'(p.np_m1) + 8'(p.subclass)
                 + 8'(p.rep.s_field) + 8'(p.st.jesdv) + 8'(p.rep.cf) + 8'(p.rep.hd);
    end

    // The result is refreshed every cycle after reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sum_reg <= RST_VALUE;
        end else begin
            sum_reg <= sum_next;
        end
    end

endmodule : lane_checksum

// [hw/serial_tx_link_config_regs.sv]
// Link transmitter configuration bank: subclass, sample format, link report, checksums and lane control.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "link_cfg.svh"
module serial_tx_link_config_regs
    import link_pkg::*;
(
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write channels.
    input  wire logic [15:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels.
    input  wire logic [15:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Link parameters from the framer and the rest of the bank.
    input  wire link_report_t link_report,
    input  wire link_static_t link_static,
    // Logical lane words from the framer.
    input  wire lane_bus_t   logical_lane_data,
    // Configuration seen by the link transmitter.
    output logic [2:0]       subclass_reg,
    output logic [4:0]       np_field_reg,
    output logic [5:0]       samples_per_frame_reg,
    output logic [7:0]       lane0_checksum_reg,
    output logic [7:0]       lane1_checksum_reg,
    // Physical lanes.
    output logic             lane0_power_down_reg,
    output logic             lane1_power_down_reg,
    output logic [7:0]       serial_out_lane_zero_reg,
    output logic [7:0]       serial_out_lane_one_reg
);

    // ****************************************************************
    // Internal signals.
    // ****************************************************************
    logic         wr_en;
    reg_wr_t      wr;
    logic         wr_ok;
    logic         wr_byte;
    logic [15:0]  wr_idx;
    logic [15:0]  rd_idx;
    logic [31:0]  rd_data;
    logic         rd_ok;
    logic [7:0]   subclass_bits_reg;
    logic [7:0]   lane_pdown_reg;
    logic [7:0]   lane0_assign_reg;
    link_report_t report_reg;
    cksum_in_t    cksum_lane0;
    cksum_in_t    cksum_lane1;
    logic [7:0]   cksum0;
    logic [7:0]   cksum1;
    logic [7:0]   lane0_word;
    logic [2:0]   lane0_sel;

    // ****************************************************************
    // Bus front end.
    // ****************************************************************

    // The slave handles handshakes and answers; this module decodes.
    axil_reg_slave u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_en   (wr_en),
        .wr      (wr),
        .wr_ok   (wr_ok),
        .rd_data (rd_data),
        .rd_ok   (rd_ok)
    );

    // Word addresses; the low two bits must be zero to hit a register.
    assign wr_idx  = {2'b00, wr.addr[15:2]};
    assign rd_idx  = {2'b00, araddr[15:2]};
    assign wr_byte = wr_en && wr.strb[0];

    // ****************************************************************
    // Write decode.
    // ****************************************************************

    // Every mapped register accepts a write; read-only ones ignore the data.
    always_comb begin
        wr_ok = 1'b0;
        if (wr.addr[1:0] == 2'b00) begin
            unique case (wr_idx)
                `IDX_SUBCLASS_BITS,
                `IDX_SAMPLES_FRAME,
                `IDX_DENSITY_CTRL,
                `IDX_LANE0_CKSUM,
                `IDX_LANE1_CKSUM,
                `IDX_LANE_PDOWN,
                `IDX_LANE0_ASSIGN: wr_ok = 1'b1;
                default:           wr_ok = 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // Writable registers.
    // ****************************************************************

    // Subclass and N' minus one share one byte.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            subclass_bits_reg <= `RST_SUBCLASS_BITS;
        end else if (wr_byte && wr_ok && wr_idx == `IDX_SUBCLASS_BITS) begin
            subclass_bits_reg <= wr.data[7:0];
        end
    end

    // All eight power-down bits are writable; reserved ones reset to one.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lane_pdown_reg <= `RST_LANE_PDOWN;
        end else if (wr_byte && wr_ok && wr_idx == `IDX_LANE_PDOWN) begin
            lane_pdown_reg <= wr.data[7:0];
        end
    end

    // Bits 7 and 3 of the assignment byte are read-only zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lane0_assign_reg <= `RST_LANE0_ASSIGN;
        end else if (wr_byte && wr_ok && wr_idx == `IDX_LANE0_ASSIGN) begin
            lane0_assign_reg <= {1'b0, wr.data[`ASSIGN_RSV_MSB:`ASSIGN_RSV_LSB],
                                 1'b0, wr.data[`ASSIGN_SEL_MSB:`ASSIGN_SEL_LSB]};
        end
    end

    // ****************************************************************
    // Link report capture.
    // ****************************************************************

    // The framer's report is held so reads and checksums see a clean value.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            report_reg <= '0;
        end else begin
            report_reg <= link_report;
        end
    end

    // ****************************************************************
    // Read decode.
    // ****************************************************************

    // Reserved bits of the sample and density bytes read as their fixed values; unmapped words answer SLVERR.
    always_comb begin
        rd_data = 32'h00000000;
        rd_ok   = 1'b0;
        if (araddr[1:0] == 2'b00) begin
            rd_ok = 1'b1;
            unique case (rd_idx)
                `IDX_SUBCLASS_BITS: rd_data[7:0] = subclass_bits_reg;
                `IDX_SAMPLES_FRAME: rd_data[7:0] = {`SAMPLES_RSV_VALUE, report_reg.s_field};
                `IDX_DENSITY_CTRL:  rd_data[7:0] = {report_reg.hd, 2'b00, report_reg.cf};
                `IDX_LANE0_CKSUM:   rd_data[7:0] = cksum0;
                `IDX_LANE1_CKSUM:   rd_data[7:0] = cksum1;
                `IDX_LANE_PDOWN:    rd_data[7:0] = lane_pdown_reg;
                `IDX_LANE0_ASSIGN:  rd_data[7:0] = lane0_assign_reg;
                default:            rd_ok = 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // Lane checksums.
    // ****************************************************************

    // Both lanes share every parameter except their lane number.
    always_comb begin
        cksum_lane0          = '0;
        cksum_lane0.st       = link_static;
        cksum_lane0.rep      = report_reg;
        cksum_lane0.np_m1    = subclass_bits_reg[`NP_MSB:`NP_LSB];
        cksum_lane0.subclass = subclass_bits_reg[`SUBCLASS_MSB:`SUBCLASS_LSB];
        cksum_lane1          = cksum_lane0;
    end

    // Lane 0 adds lane number zero.
    lane_checksum #(
        .LANE_ID   (`LANE0_LID),
        .RST_VALUE (`RST_LANE0_CKSUM)
    ) u_cksum0 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .p       (cksum_lane0),
        .sum_reg (cksum0)
    );

    // Lane 1 adds lane number one.
    lane_checksum #(
        .LANE_ID   (`LANE1_LID),
        .RST_VALUE (`RST_LANE1_CKSUM)
    ) u_cksum1 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .p       (cksum_lane1),
        .sum_reg (cksum1)
    );

    // ****************************************************************
    // Lane crossbar for physical lane 0.
    // ****************************************************************

    assign lane0_sel = lane0_assign_reg[`ASSIGN_SEL_MSB:`ASSIGN_SEL_LSB];

    // Codes 0 to 3 pick a logical lane; codes 4 to 7 send zeros.
    always_comb begin
        lane0_word = 8'h00;
        if (!lane0_sel[2]) begin
            lane0_word = logical_lane_data[lane0_sel[1:0]];
        end
    end

    // ****************************************************************
    // Registered outputs.
    // ****************************************************************

    // Format settings and samples per frame as a count.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            subclass_reg          <= 3'(`RST_SUBCLASS_BITS >> `SUBCLASS_LSB);
            np_field_reg          <= 5'(`RST_SUBCLASS_BITS);
            samples_per_frame_reg <= 6'h01;
        end else begin
            subclass_reg          <= subclass_bits_reg[`SUBCLASS_MSB:`SUBCLASS_LSB];
            np_field_reg          <= subclass_bits_reg[`NP_MSB:`NP_LSB];
            samples_per_frame_reg <= 6'(report_reg.s_field) + 6'h01;
        end
    end

    // Checksums as seen by the lane alignment sequence.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lane0_checksum_reg <= `RST_LANE0_CKSUM;
            lane1_checksum_reg <= `RST_LANE1_CKSUM;
        end else begin
            lane0_checksum_reg <= cksum0;
            lane1_checksum_reg <= cksum1;
        end
    end

    // Power-down controls to the serializers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lane0_power_down_reg <= 1'b0;
            lane1_power_down_reg <= 1'b0;
        end else begin
            lane0_power_down_reg <= lane_pdown_reg[`PDOWN_LANE0_BIT];
            lane1_power_down_reg <= lane_pdown_reg[`PDOWN_LANE1_BIT];
        end
    end

    // Lane words; a powered-down lane carries zeros.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_out_lane_zero_reg <= 8'h00;
            serial_out_lane_one_reg  <= 8'h00;
        end else begin
            serial_out_lane_zero_reg <= lane_pdown_reg[`PDOWN_LANE0_BIT] ? 8'h00 : lane0_word;
            serial_out_lane_one_reg  <= lane_pdown_reg[`PDOWN_LANE1_BIT] ? 8'h00
                                                                         : logical_lane_data[1];
        end
    end

endmodule : serial_tx_link_config_regs

// [tb/serial_tx_link_config_regs_checker.sv]
// Port-level assertions for the link configuration bank.
`timescale 1ns/1ps
`include "link_cfg.svh"
module serial_tx_link_config_regs_checker
    import link_pkg::*;
(
    // Clock and reset.
    input wire logic         aclk,
    input wire logic         aresetn,
    // Bus handshakes.
    input wire logic [15:0]  awaddr,
    input wire logic         awvalid,
    input wire logic         awready,
    input wire logic [31:0]  wdata,
    input wire logic [3:0]   wstrb,
    input wire logic         wvalid,
    input wire logic         wready,
    input wire logic         bvalid,
    input wire logic         bready,
    input wire logic         arvalid,
    input wire logic         arready,
    input wire logic         rvalid,
    input wire logic         rready,
    // Link side.
    input wire link_report_t link_report,
    input wire lane_bus_t    logical_lane_data,
    input wire logic [2:0]   subclass_reg,
    input wire logic [5:0]   samples_per_frame_reg,
    input wire logic [7:0]   lane0_checksum_reg,
    input wire logic [7:0]   lane1_checksum_reg,
    input wire logic         lane0_power_down_reg,
    input wire logic         lane1_power_down_reg,
    input wire logic [7:0]   serial_out_lane_zero_reg,
    input wire logic [7:0]   serial_out_lane_one_reg
);
    // ****************************************************************
    // Assertions.
    // ****************************************************************
    localparam logic [15:0] SUB_ADDR = `IDX_SUBCLASS_BITS << 2;
    localparam logic [15:0] PD_ADDR  = `IDX_LANE_PDOWN << 2;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // A write whose address and data are taken at one edge, with byte 0 enabled.
    sequence wr_to(logic [15:0] a);
        awvalid && awready && wvalid && wready && awaddr == a && wstrb[0];
    endsequence
    // The response comes on the second edge after the take.
    sequence wr_answer;
        !awready && !bvalid ##1 bvalid;
    endsequence

    write_resp_a: assert property (awvalid && awready && wvalid && wready |=> wr_answer)
        else $error("Write response late or early.");
    write_done_a: assert property (bvalid && bready |=> !bvalid && awready && wready)
        else $error("Write channel not freed.");
    read_resp_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("Read response late.");
    read_done_a: assert property (rvalid && rready |=> !rvalid && arready)
        else $error("Read channel not freed.");
    subclass_write_a: assert property (wr_to(SUB_ADDR) |=> ##2 subclass_reg == $past(wdata[7:5], 3))
        else $error("Subclass output wrong after write.");
    pdown_write_a: assert property (wr_to(PD_ADDR) |=> ##2 lane0_power_down_reg == $past(wdata[0], 3)
        && lane1_power_down_reg == $past(wdata[2], 3)) else $error("Power-down outputs wrong after write.");
    samples_plus_a: assert property ($past(aresetn) && $past(aresetn, 2)
        |-> samples_per_frame_reg == $past(link_report.s_field, 2) + 6'h01) else $error("Sample count wrong.");
    lane1_data_a: assert property ($past(aresetn) |-> serial_out_lane_one_reg
        == (lane1_power_down_reg ? 8'h00 : $past(logical_lane_data[1]))) else $error("Lane one data wrong.");
    lane0_off_a: assert property (lane0_power_down_reg |-> serial_out_lane_zero_reg == 8'h00)
        else $error("Lane zero not silent.");
    cksum_lane_a: assert property (lane1_checksum_reg == lane0_checksum_reg + 8'h01)
        else $error("Checksums do not differ by the lane id.");
    cksum_reset_a: assert property ($rose(aresetn) |-> lane0_checksum_reg == 8'hc3 && lane1_checksum_reg == 8'hc4)
        else $error("Checksum reset values wrong.");
endmodule : serial_tx_link_config_regs_checker

bind serial_tx_link_config_regs serial_tx_link_config_regs_checker i_chk (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready,
    .link_report, .logical_lane_data, .subclass_reg, .samples_per_frame_reg, .lane0_checksum_reg,
    .lane1_checksum_reg, .lane0_power_down_reg, .lane1_power_down_reg, .serial_out_lane_zero_reg,
    .serial_out_lane_one_reg);

// [tb/tb.sv]
// Self-checking bench for the link configuration bank over AXI4-Lite.
`timescale 1ns/1ps
`include "link_cfg.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_count++; $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb
    import link_pkg::*;
;
    // ****************************************************************
    // Signals, clock and design.
    // ****************************************************************
    localparam logic [15:0] A_SUB = `IDX_SUBCLASS_BITS << 2;
    localparam logic [15:0] A_SMP = `IDX_SAMPLES_FRAME << 2;
    localparam logic [15:0] A_DEN = `IDX_DENSITY_CTRL << 2;
    localparam logic [15:0] A_CK0 = `IDX_LANE0_CKSUM << 2;
    localparam logic [15:0] A_CK1 = `IDX_LANE1_CKSUM << 2;
    localparam logic [15:0] A_PD  = `IDX_LANE_PDOWN << 2;
    localparam logic [15:0] A_ASG = `IDX_LANE0_ASSIGN << 2;
    logic         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic         awready, wready, bvalid, arready, rvalid, pd0, pd1;
    logic [15:0]  awaddr, araddr;
    logic [31:0]  wdata, rdata;
    logic [3:0]   wstrb;
    logic [1:0]   bresp, rresp;
    link_report_t rep;
    link_static_t st;
    lane_bus_t    lanes;
    logic [2:0]   sub;
    logic [4:0]   np;
    logic [5:0]   spf;
    logic [7:0]   ck0, ck1, out0, out1;
    int           err_count, tests_run;
    logic [7:0]   sub_tab [4] = '{8'h07, 8'h2f, 8'h0f, 8'h27};
    logic [7:0]   pd_tab [4]  = '{8'hfb, 8'hfe, 8'hff, 8'hfa}; // Reserved ones kept set.

    // Free-running 50 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    serial_tx_link_config_regs i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .link_report(rep), .link_static(st),
        .logical_lane_data(lanes), .subclass_reg(sub), .np_field_reg(np), .samples_per_frame_reg(spf),
        .lane0_checksum_reg(ck0), .lane1_checksum_reg(ck1), .lane0_power_down_reg(pd0),
        .lane1_power_down_reg(pd1), .serial_out_lane_zero_reg(out0), .serial_out_lane_one_reg(out1));

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // One write; address and data are released as each is taken.
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
        int n;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 50) begin
            err_count++;
            conclude();
        end
        `CHK(bresp, exp_resp)
    endtask : wr

    // One read, compared with the expected word and response.
    task automatic rd(input logic [15:0] a, input logic [31:0] exp_data, input logic [1:0] exp_resp);
        int n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 50) begin
            err_count++;
            conclude();
        end
        `CHK(rdata, exp_data)
        `CHK(rresp, exp_resp)
    endtask : rd

    // Lets register, report and lane pipelines land before outputs are looked at.
    task automatic settle();
        repeat (3) @(posedge aclk);
        #1;
    endtask : settle

    // Expected lane checksum for the current inputs and subclass byte.
    function automatic logic [7:0] cks(input logic [7:0] lid, input logic [7:0] sb);
        return st.did + st.bid + lid + st.scr + st.l_m1 + st.f_m1 + st.k_m1 + st.m_m1 + st.cs + st.n_m1
            + sb[4:0] + sb[7:5] + rep.s_field + st.jesdv + rep.cf + rep.hd;
    endfunction : cks

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        rep   = '0;
        st    = '{8'h5a, 4'h3, 1'b1, 5'h01, 8'h01, 5'h1f, 8'h03, 2'h2, 5'h0d, 3'h1};
        lanes = {8'hd4, 8'hc3, 8'hb2, 8'ha1};
        repeat (16) @(posedge aclk);
        #1;
        `CHK(ck0, 8'hc3)
        `CHK(ck1, 8'hc4)
        @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_SUB, 32'h2f, RESP_OKAY);
        rd(A_SMP, 32'h20, RESP_OKAY);
        rd(A_DEN, 32'h00, RESP_OKAY);
        rd(A_PD, 32'hfa, RESP_OKAY);
        rd(A_ASG, 32'h00, RESP_OKAY);
        rep <= '{hd: 1'b1, cf: 5'h1a, s_field: 5'h1f};
        settle();
        `CHK(spf, 6'h20)
        rd(A_SMP, 32'h3f, RESP_OKAY);
        wr(A_DEN, 32'h00, RESP_OKAY);
        rd(A_DEN, 32'h9a, RESP_OKAY);
        foreach (sub_tab[i]) begin
            wr(A_SUB, {24'h0, sub_tab[i]}, RESP_OKAY);
            settle();
            `CHK(sub, sub_tab[i][7:5])
            `CHK(np, sub_tab[i][4:0])
            `CHK(ck0, cks(8'h00, sub_tab[i]))
            rd(A_CK1, {24'h0, cks(8'h01, sub_tab[i])}, RESP_OKAY);
            rd(A_SUB, {24'h0, sub_tab[i]}, RESP_OKAY);
        end
        foreach (pd_tab[i]) begin
            wr(A_PD, {24'h0, pd_tab[i]}, RESP_OKAY);
            settle();
            `CHK(pd0, pd_tab[i][0])
            `CHK(pd1, pd_tab[i][2])
            `CHK(out0, pd_tab[i][0] ? 8'h00 : lanes[0])
            `CHK(out1, pd_tab[i][2] ? 8'h00 : lanes[1])
            rd(A_PD, {24'h0, pd_tab[i]}, RESP_OKAY);
        end
        for (int s = 0; s < 5; s++) begin
            wr(A_ASG, 32'(s), RESP_OKAY);
            settle();
            `CHK(out0, s < 4 ? lanes[s] : 8'h00)
            rd(A_ASG, 32'(s), RESP_OKAY);
        end
        rd(16'h1700, 32'h0, RESP_SLVERR);
        wr(A_SUB + 16'h0002, 32'hff, RESP_SLVERR);
        rd(A_SUB, 32'h27, RESP_OKAY);
        conclude();
    end
endmodule : tb
